// ### pkg/pwm_seq_pkg.sv
// Package: constants and carrier types for the multi-channel PWM sequencer
package pwm_seq_pkg;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'hffff;
  localparam int SLAVE_N = 2;
  // Trigger bit positions within the start/stop trigger vectors
  localparam int TRG_MASTER = 0;
  localparam int TRG_SLAVE1 = 1;
  localparam int TRG_SLAVE2 = 2;
  localparam int TRG_W = 3;
  // Default prescaler divide (count clock = system clock / value)
  localparam int COUNT_DIV = 1;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic output_enable;
    logic output_mode_bit;
    logic output_level_bit;
    logic output_value;
  } slave_cfg_t;

  typedef enum logic [0:0] {
    SLAVE_IDLE = 1'b0,
    SLAVE_COUNT = 1'b1
  } slave_state_t;
endpackage : pwm_seq_pkg

// ### logic/pwm_slave_channel.sv
// Slave channel: one-shot duty counter restarted by the master period event
`timescale 1ns/1ps
module pwm_slave_channel
  import pwm_seq_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic unit_on_in,
  input wire logic count_en_in,
  input wire logic running_in,
  input wire logic trigger_in,
  input wire logic [W-1:0] duty_value_in,
  input wire slave_cfg_t cfg_in,
  output logic [W-1:0] counter_out,
  output logic pin_out
);
  slave_state_t state;
  slave_state_t next_state;
  logic [W-1:0] next_counter;
  logic level;
  logic next_level;
  logic pin_value;
  wire logic at_zero = (counter_out == W'(0));
  wire logic step = running_in && count_en_in;

  // ****************************************
  // Counter and state
  // ****************************************
  // Trigger has priority so a period that ends in the same count as the duty restarts cleanly
  always_comb begin
    next_state = state;
    next_counter = counter_out;
    next_level = level;
    if (step && trigger_in) begin
      next_state = SLAVE_COUNT;
      next_counter = duty_value_in;
      next_level = (duty_value_in != W'(0));
    end else if (step) begin
      case (state)
        SLAVE_COUNT: begin
          if (at_zero) begin
            next_state = SLAVE_IDLE;
            next_level = 1'b0;
          end else begin
            next_counter = counter_out - W'(1);
            if (counter_out == W'(1)) begin
              next_level = 1'b0;
              next_state = SLAVE_IDLE;
            end
          end
        end
        default: begin
          next_state = SLAVE_IDLE;
        end
      endcase
    end
  end

  // Power-enable low puts every bit back to its reset value
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= SLAVE_IDLE;
      counter_out <= W'(CNT_RESET);
      level <= 1'b0;
    end else if (!unit_on_in) begin
      state <= SLAVE_IDLE;
      counter_out <= W'(CNT_RESET);
      level <= 1'b0;
    end else begin
      state <= next_state;
      counter_out <= next_counter;
      level <= next_level;
    end
  end

  // ****************************************
  // Pin selection
  // ****************************************
  // Outside combination mode the counter level is not used
  wire logic gen_level = cfg_in.output_mode_bit ? level : 1'b0;
  wire logic shaped = gen_level ^ cfg_in.output_level_bit;
  assign pin_value = cfg_in.output_enable ? shaped : cfg_in.output_value;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out <= 1'b0;
    end else if (!unit_on_in) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= pin_value;
    end
  end
endmodule : pwm_slave_channel

// ### logic/multi_channel_pwm_sequencer.sv
// Top: master period channel, two slave duty channels and trigger handling
`timescale 1ns/1ps
// Functional notes
// - Start triggers self-clear after write
// - Start sets all three running flags
// - Master start raises period interrupt immediately
// - Master reloads period at zero, interrupts
// - Slave1 loads duty on period interrupt
// - Slave1 active one clock after interrupt
// - Slave1 inactive at zero, then halts
// - Slave2 behaves exactly like slave1
// - Counters readable at any time
// - Stop clears running flags, holds counts
// - Stop keeps slave output levels
// - Output enable low drives software value
// - Power-enable low resets everything, port mode
// - Level bit selects active high or low
// - Mode bit one selects combination mode
module multi_channel_pwm_sequencer
  import pwm_seq_pkg::*;
#(
  parameter int W = CNT_W,
  parameter int DIV = COUNT_DIV
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic timer_unit_power_enable_in,
  input wire logic count_tick_in,
  input wire logic trigger_write_in,
  input wire logic [TRG_W-1:0] start_trigger_in,
  input wire logic [TRG_W-1:0] stop_trigger_in,
  input wire logic [W-1:0] master_period_value_in,
  input wire logic [W-1:0] slave1_duty_value_in,
  input wire logic [W-1:0] slave2_duty_value_in,
  input wire slave_cfg_t slave1_cfg_in,
  input wire slave_cfg_t slave2_cfg_in,
  output logic [TRG_W-1:0] channel_start_trigger_reg_out,
  output logic [TRG_W-1:0] running_flags_out,
  output logic [W-1:0] master_counter_out,
  output logic [W-1:0] slave1_counter_out,
  output logic [W-1:0] slave2_counter_out,
  output logic master_period_interrupt_out,
  output logic slave1_output_out,
  output logic slave2_output_out,
  output logic slave1_output_oe_out,
  output logic slave2_output_oe_out
);
  logic [TRG_W-1:0] running;
  logic [TRG_W-1:0] next_running;
  logic [W-1:0] next_master;
  logic start_pending;
  logic [15:0] div_cnt;
  logic div_pulse;

  // ****************************************
  // Count clock enable
  // ****************************************
  // Divider gives the count clock; an external tick can also gate it
  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);
  assign div_pulse = (div_cnt == DIV_LAST) && count_tick_in;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt <= 16'h0000;
    end else if (!timer_unit_power_enable_in || div_pulse) begin
      div_cnt <= 16'h0000;
    end else if (count_tick_in) begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  wire logic count_en = div_pulse;

  // ****************************************
  // Trigger decode
  // ****************************************
  // Zero bits are ignored, so only ones act; stop wins if both are written
  wire logic [TRG_W-1:0] start_hit = trigger_write_in ? start_trigger_in : '0;
  wire logic [TRG_W-1:0] stop_hit = trigger_write_in ? stop_trigger_in : '0;
  assign next_running = (running | start_hit) & ~stop_hit;
  wire logic master_start = start_hit[TRG_MASTER] && !stop_hit[TRG_MASTER];
  wire logic master_run = running[TRG_MASTER];
  wire logic master_zero = (master_counter_out == W'(0));

  // Trigger register never holds a value: it reads zero after the write cycle
  assign channel_start_trigger_reg_out = '0;
  assign running_flags_out = running;

  // ****************************************
  // Running flags and start pending
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      running <= '0;
      start_pending <= 1'b0;
    end else if (!timer_unit_power_enable_in) begin
      running <= '0;
      start_pending <= 1'b0;
    end else begin
      running <= next_running;
      if (master_start) begin
        start_pending <= 1'b1;
      end else if (!next_running[TRG_MASTER] || (master_run && count_en)) begin
        start_pending <= 1'b0;
      end
    end
  end

  // ****************************************
  // Master counter and period event
  // ****************************************
  // First count after start loads the period and fires the event at once
  wire logic period_event = master_run && count_en && (start_pending || master_zero);
  always_comb begin
    next_master = master_counter_out;
    if (period_event) begin
      next_master = master_period_value_in;
    end else if (master_run && count_en) begin
      next_master = master_counter_out - W'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      master_counter_out <= W'(CNT_RESET);
      master_period_interrupt_out <= 1'b0;
    end else if (!timer_unit_power_enable_in) begin
      master_counter_out <= W'(CNT_RESET);
      master_period_interrupt_out <= 1'b0;
    end else begin
      master_counter_out <= next_master;
      master_period_interrupt_out <= period_event;
    end
  end

  // ****************************************
  // Slave channels
  // ****************************************
  // Slaves start on the master event, not on their own start bits
  pwm_slave_channel #(.W(W)) u_slave1 (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .unit_on_in(timer_unit_power_enable_in),
    .count_en_in(count_en),
    .running_in(running[TRG_SLAVE1]),
    .trigger_in(period_event),
    .duty_value_in(slave1_duty_value_in),
    .cfg_in(slave1_cfg_in),
    .counter_out(slave1_counter_out),
    .pin_out(slave1_output_out)
  );

  pwm_slave_channel #(.W(W)) u_slave2 (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .unit_on_in(timer_unit_power_enable_in),
    .count_en_in(count_en),
    .running_in(running[TRG_SLAVE2]),
    .trigger_in(period_event),
    .duty_value_in(slave2_duty_value_in),
    .cfg_in(slave2_cfg_in),
    .counter_out(slave2_counter_out),
    .pin_out(slave2_output_out)
  );

  // Pins fall back to port mode while the unit is powered off
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slave1_output_oe_out <= 1'b0;
      slave2_output_oe_out <= 1'b0;
    end else begin
      slave1_output_oe_out <= timer_unit_power_enable_in;
      slave2_output_oe_out <= timer_unit_power_enable_in;
    end
  end
endmodule : multi_channel_pwm_sequencer

// ### tb/pwm_seq_assertions.sv
// Port checker for the multi-channel PWM sequencer
`timescale 1ns/1ps
module pwm_seq_checker
  import pwm_seq_pkg::*;
#(parameter int W = CNT_W) (
  input wire logic clk_sys_in, nrst_in, timer_unit_power_enable_in, trigger_write_in,
  input wire logic [TRG_W-1:0] start_trigger_in, stop_trigger_in,
  input wire logic [TRG_W-1:0] channel_start_trigger_reg_out, running_flags_out,
  input wire logic [W-1:0] master_period_value_in, slave1_duty_value_in,
  input wire logic [W-1:0] master_counter_out, slave1_counter_out,
  input wire slave_cfg_t slave1_cfg_in,
  input wire logic master_period_interrupt_out, slave1_output_out, slave2_output_out,
  input wire logic slave1_output_oe_out, slave2_output_oe_out, count_tick_in
);
  // ****
  // Properties, one clock domain
  // ****
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  wire pw = timer_unit_power_enable_in;
  wire st7 = pw && trigger_write_in && stop_trigger_in == 3'h7;
  a_trig_self_clear: assert property (channel_start_trigger_reg_out == 3'h0)
    else $error("start trigger bits read back nonzero");
  a_start_sets_run: assert property (pw && trigger_write_in && start_trigger_in == 3'h7
    && stop_trigger_in == 3'h0 ##1 pw |-> running_flags_out == 3'h7)
    else $error("start did not set running flags");
  a_start_irq_now: assert property (pw && trigger_write_in && start_trigger_in[0]
    && !stop_trigger_in[0] && !running_flags_out[0] ##1 pw && count_tick_in
    |=> master_period_interrupt_out)
    else $error("no period interrupt after start");
  a_zero_reload: assert property (pw && running_flags_out[0] && master_counter_out == 16'h0000
    && count_tick_in |=> master_period_interrupt_out
    && master_counter_out == $past(master_period_value_in))
    else $error("master did not reload at zero");
  a_duty_load: assert property (master_period_interrupt_out
    |-> slave1_counter_out == $past(slave1_duty_value_in))
    else $error("slave duty not loaded on period event");
  a_slave_active: assert property (pw && master_period_interrupt_out && slave1_cfg_in == 4'hc
    && slave1_counter_out != 16'h0000 |=> slave1_output_out)
    else $error("slave output not active after period event");
  a_slave_end: assert property (pw && $past(slave1_counter_out) == 16'h0001
    && slave1_counter_out == 16'h0000 && slave1_cfg_in == 4'hc |=> !slave1_output_out)
    else $error("slave output still active at count end");
  a_stop_holds: assert property (st7 ##1 pw |=> running_flags_out == 3'h0
    && $stable(master_counter_out) && $stable(slave1_counter_out))
    else $error("counting went on after stop");
  a_stop_pins: assert property (st7 ##1 pw ##1 pw |=> $stable(slave1_output_out)
    && $stable(slave2_output_out))
    else $error("slave pins changed after stop");
  a_manual_level: assert property (pw && !slave1_cfg_in.output_enable
    |=> slave1_output_out == $past(slave1_cfg_in.output_value))
    else $error("pin does not follow software value");
  a_power_off: assert property (!pw |=> !slave1_output_oe_out && !slave2_output_oe_out
    && running_flags_out == 3'h0)
    else $error("power off did not clear state");
endmodule : pwm_seq_checker

bind multi_channel_pwm_sequencer pwm_seq_checker #(.W(W)) i_pwm_seq_checker (.*);

// ### tb/pwm_load.sv
// Load model: measures the last high time seen on a PWM pin
`timescale 1ns/1ps
module pwm_load (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic pin_in,
  input wire logic oe_in,
  output logic [15:0] high_len_out
);
  int cnt;
  // Count high cycles; a pin not driven counts as low
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt = 0;
      high_len_out <= 16'h0000;
    end else if (oe_in && pin_in) cnt++;
    else begin
      if (cnt != 0) high_len_out <= 16'(cnt);
      cnt = 0;
    end
  end
endmodule : pwm_load

// ### tb/multi_channel_pwm_sequencer_tb_top.sv
// Testbench: cycle model of the sequencer compared with the design
`timescale 1ns/1ps
module multi_channel_pwm_sequencer_tb_top;
  import pwm_seq_pkg::*;
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, pw = 1'b1, tw = 1'b0;
  logic [2:0] stt = 3'h0, stp = 3'h0, trg_q, run_q, run;
  logic [15:0] per = 16'h0005, du1 = 16'h0002, du2 = 16'h0003, hl, mc_q, s1_q, s2_q;
  slave_cfg_t c1 = 4'hc, c2 = 4'hc, cf;
  logic irq_q, p1, p2, oe1, oe2, tk = 1'b1, rt = 1'b0;
  int n_fail = 0, total_checks = 0, cyc = 0, seed = 96365, mc, p, d, r, irq, pend, oe, ev, rr;
  int sc[2], lv[2], pn[2];
  initial forever #10 clk_sys_in = ~clk_sys_in;
  multi_channel_pwm_sequencer #(.W(16), .DIV(1)) i_multi_channel_pwm_sequencer (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .timer_unit_power_enable_in(pw),
    .count_tick_in(tk), .trigger_write_in(tw), .start_trigger_in(stt),
    .stop_trigger_in(stp), .master_period_value_in(per), .slave1_duty_value_in(du1),
    .slave2_duty_value_in(du2), .slave1_cfg_in(c1), .slave2_cfg_in(c2),
    .channel_start_trigger_reg_out(trg_q), .running_flags_out(run_q),
    .master_counter_out(mc_q), .slave1_counter_out(s1_q), .slave2_counter_out(s2_q),
    .master_period_interrupt_out(irq_q), .slave1_output_out(p1), .slave2_output_out(p2),
    .slave1_output_oe_out(oe1), .slave2_output_oe_out(oe2));
  pwm_load i_pwm_load (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .pin_in(p1),
    .oe_in(oe1), .high_len_out(hl));
  // ****
  // Reference model; power off behaves like reset
  // ****
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in || !pw) begin
      mc = 65535; sc = '{65535, 65535}; lv = '{0, 0}; pn = '{0, 0};
      run = 3'h0; irq = 0; pend = 0; oe = 0;
    end else begin
      ev = run[0] && tk && (pend != 0 || mc == 0);
      irq = ev;
      oe = 1;
      for (int i = 0; i < 2; i++) begin
        cf = i ? c2 : c1;
        pn[i] = cf.output_enable ? (cf.output_mode_bit & lv[i][0]) ^ cf.output_level_bit
          : cf.output_value;
        if (ev && run[i+1]) begin sc[i] = i ? du2 : du1; lv[i] = (sc[i] != 0); end
        else if (tk && run[i+1] && sc[i] != 0) begin sc[i]--; if (sc[i] == 0) lv[i] = 0; end
      end
      mc = ev ? per : mc - (run[0] && tk);
      // A start waits for the first count clock; a stop drops it
      if (tw && stt[0] && !stp[0]) pend = 1;
      else if (!run[0] || tk || (tw && stp[0])) pend = 0;
      if (tw) run = (run | stt) & ~stp;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Compare at the falling edge, once every registered output has settled
  always @(negedge clk_sys_in) if (nrst_in) begin
    check(mc_q, 16'(mc));
    check(s1_q, 16'(sc[0]));
    check(s2_q, 16'(sc[1]));
    check(16'(run_q), 16'(run));
    check(16'(irq_q), 16'(irq));
    check(16'(p1), 16'(pn[0]));
    check(16'(p2), 16'(pn[1]));
    check(16'({oe1, oe2}), 16'({2{oe[0]}}));
    check(16'(trg_q), 16'h0000);
  end
  task automatic trig(input logic [2:0] st, input logic [2:0] sp);
    @(posedge clk_sys_in); tw <= 1'b1; stt <= st; stp <= sp;
    @(posedge clk_sys_in); tw <= 1'b0; stt <= 3'h0; stp <= 3'h0;
  endtask : trig
  task automatic wait_irq;
    @(posedge clk_sys_in);
    while (irq_q !== 1'b1) @(posedge clk_sys_in);
  endtask : wait_irq
  task automatic final_report;
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Hang guard: a run this short never needs more cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    // Count clock with random gaps while rt is set
    if (rt) begin
      rr = $random(seed);
      tk <= rr[0];
    end else begin
      tk <= 1'b1;
    end
    if (cyc == 5000) begin n_fail++; final_report; end
  end
  // ****
  // Main sequence: four output setups
  // ****
  initial begin
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      p = 3 + {$random(seed)} % 8;
      @(posedge clk_sys_in); per <= 16'(p); du1 <= 16'(1 + {$random(seed)} % p);
      du2 <= 16'(1 + {$random(seed)} % p);
      rt <= (k == 3);
      c1 <= {2'b11, k[0], 1'b0}; c2 <= {1'b1, k[1], k[0], 1'b0};
      trig(3'h7, 3'h0);
      wait_irq;
      d = 1 + {$random(seed)} % p;
      @(posedge clk_sys_in); du1 <= 16'(d);
      wait_irq;
      repeat (d + 3) @(posedge clk_sys_in);
      if (!k[0]) check(hl, 16'(d));
      trig(3'h0, 3'h0);
      trig(3'h0, 3'h7);
      repeat (4) @(posedge clk_sys_in);
      r = $random(seed);
      c1 <= {1'b0, c1[2:1], r[0]};
      repeat (3) @(posedge clk_sys_in);
      c1 <= {1'b1, c1[2:0]};
      if (k[1]) begin trig(3'h7, 3'h0); repeat (p) @(posedge clk_sys_in); end
      pw <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      pw <= 1'b1;
    end
    repeat (3) @(posedge clk_sys_in);
    final_report;
  end
endmodule : multi_channel_pwm_sequencer_tb_top
